// File: src/csm_pkg.sv
package csm_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS        = 40;
  // Trim must finish within this time: round down
  localparam int CAL_TRIM_TIME_NS     = 100000;
  localparam int CAL_TRIM_CYCLES      = CAL_TRIM_TIME_NS / CLK_PERIOD_NS;
  // Overcurrent must persist at least this long: round up
  localparam int OCP_DEGLITCH_TIME_NS = 4000;
  localparam int OCP_DEGLITCH_CYCLES  = (OCP_DEGLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_CNT_W            = 12;
  localparam int OCP_CNT_W            = 8;
  localparam logic [CAL_CNT_W-1:0] CAL_TRIM_LAST = CAL_CNT_W'(CAL_TRIM_CYCLES - 1);
  localparam logic [OCP_CNT_W-1:0] OCP_DEGLITCH_CNT = OCP_CNT_W'(OCP_DEGLITCH_CYCLES);
  localparam int STRAP_CNT_W          = 3;
  localparam logic [STRAP_CNT_W-1:0] STRAP_SETTLE = 3'h7;

  // ------------------------------------------------------------
  // Bus map
  // ------------------------------------------------------------
  localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
  localparam logic [31:0] ADDR_CAL    = 32'h0000_0004;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
  localparam logic [2:0]  SIZE_WORD   = 3'h2;
  localparam int          HTRANS_ACTIVE_BIT = 1;

  // ------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------
  localparam logic [1:0] GAIN_5   = 2'h0;
  localparam logic [1:0] GAIN_10  = 2'h1;
  localparam logic [1:0] GAIN_20  = 2'h2;
  localparam logic [1:0] GAIN_40  = 2'h3;
  localparam logic       LOW_SIDE_MONITOR_REF_SEL_POS = 1'b0;
  localparam logic       LOW_SIDE_MONITOR_REF_SEL_NEG = 1'b1;
  localparam logic [1:0] FM_LATCH  = 2'h0;
  localparam logic [1:0] FM_REPORT = 2'h1;
  localparam logic [1:0] FM_IGNORE = 2'h2;
  localparam logic [2:0] HS_MON_DRAIN_SWITCH = 3'h7;
  localparam logic [2:0] SEVEN_LEVEL_MAX = 3'h6;
  localparam int         NUM_CH  = 3;
  localparam int         NUM_FET = 6;
  // Seven pin levels onto trip codes 0.06 V (code 0) .. 1.88 V (code F)
  localparam logic [3:0] HW_TRIP_CODE [0:6] = '{4'h0, 4'h2, 4'h4, 4'h7, 4'h9, 4'hC, 4'hF};

  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_TRIM = 3'b010,
    CAL_HOLD = 3'b100
  } cal_state_t;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [14:0] rsvd;
    logic [3:0]  drive_current;
    logic [1:0]  pwm_mode;
    logic [1:0]  fault_mode;
    logic        drain_sense_mode_bit;
    logic        low_side_monitor_ref_sel;
    logic        ref_div_off;
    logic [3:0]  trip_level;
    logic [1:0]  gain;
  } ctrl_t;
  localparam logic [31:0] CTRL_WMASK = 32'h0001_FFFF;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [18:0] rsvd;
    logic        hw_variant;
    logic        shutdown;
    logic        ref_bidir;
    logic [1:0]  gain_eff;
    logic        cal_busy;
    logic        trim_done;
    logic [5:0]  oc_flag;
  } status_t;

  typedef struct packed {
    logic       cal;
    logic [2:0] hs_cmp;
    logic [2:0] ls_cmp;
    logic [5:0] pwm;
    logic       hw_variant;
    logic [1:0] gain_lvl;
    logic [1:0] mode_lvl;
    logic [2:0] drv_lvl;
    logic [2:0] trip_lvl;
  } pin_in_t;
  localparam int PIN_W = $bits(pin_in_t);

endpackage : csm_pkg

// File: src/input_filter.sv
module input_filter #(
  parameter int W = 24
) (
  input  logic         clk,
  input  logic         nrst,
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] agree;

  // ------------------------------------------------------------
  // Three-stage sampler, change accepted when stages two and three agree
  // ------------------------------------------------------------
  assign agree = ~(s2_reg ^ s3_reg);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q      <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q      <= (agree & s3_reg) | (~agree & q);
    end
  end

endmodule : input_filter

// File: src/cs_vds_monitor.sv
// Notes on behaviour
// - Flag overcurrent only after persistent excess, then act
// - High-side monitor: drain sense versus switch node
// - Low-side reference selectable positive or negative input
// - Trip level spans 0.06 V to 1.88 V
// - Gain 5, 10, 20, 40 for all channels
// - Divider removed means unidirectional, else bidirectional
// - Calibration starts by pin or trim bits
// - Calibration shorts inputs, drops load, forces 40
// - Trim routine ends within 100 microseconds
// - Hold short, disconnect, gain 40 while requested
// - Request release ends calibration, gain restored
// - Calibration forces bidirectional reference when unidirectional
// - Forced reference affects all three channels
// - Every logic input passes a deglitch filter
// - Fault flag is open drain, pulled low only
// - Strap variant decodes four and seven level pins
// - Drain sense mode forces negative low-side reference
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
module cs_vds_monitor (
  input  logic        clk,
  input  logic        nrst,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic        hreadyout,
  output logic        hresp,
  output logic [31:0] hrdata,
  input  logic        cal_pin,
  input  logic [2:0]  hs_cmp_above,
  input  logic [2:0]  ls_cmp_above,
  input  logic [5:0]  pwm_in,
  input  logic        hw_variant_pin,
  input  logic [1:0]  gain_pin_level,
  input  logic [1:0]  pwm_mode_pin_level,
  input  logic [2:0]  drive_current_select_pin_level,
  input  logic [2:0]  trip_threshold_pin_level,
  output logic [1:0]  amp_gain_factor,
  output logic        ref_bidir,
  output logic        low_side_monitor_ref_sel,
  output logic [2:0]  hs_mon_sel,
  output logic [3:0]  drain_source_trip_level,
  output logic [2:0]  amp_short,
  output logic [2:0]  load_disconnect,
  output logic [2:0]  trim_run,
  output logic [5:0]  gate_cmd,
  output logic [1:0]  pwm_mode,
  output logic [3:0]  drive_current_sel,
  output logic        fault_flag_n_o,
  output logic        fault_flag_n_oe
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  csm_pkg::pin_in_t    pin_raw;
  csm_pkg::pin_in_t    pin_f;
  csm_pkg::ctrl_t      ctrl_reg;
  csm_pkg::status_t    status;
  csm_pkg::cal_state_t cal_state_reg;

  logic [csm_pkg::STRAP_CNT_W-1:0] strap_cnt_reg;
  logic                            strap_taken_reg;
  logic                            hw_variant_reg;
  logic [csm_pkg::NUM_CH-1:0]      trim_bits_reg;
  logic [csm_pkg::NUM_FET-1:0]     oc_flag_reg;
  logic [csm_pkg::NUM_FET-1:0]     oc_hit;
  logic [csm_pkg::NUM_FET-1:0]     oc_set;
  logic [csm_pkg::NUM_FET-1:0]     oc_clr;
  logic [csm_pkg::NUM_FET-1:0]     fet_cmp;
  logic [csm_pkg::CAL_CNT_W-1:0]   cal_cnt_reg;
  logic                            shutdown_reg;
  logic                            wr_pend_reg;
  logic [31:0]                     wr_addr_reg;
  logic                            addr_ok;
  logic                            wr_ctrl;
  logic                            wr_cal;
  logic                            wr_status;
  logic [31:0]                     rd_data;

  logic [1:0]                      eff_gain;
  logic [3:0]                      eff_trip;
  logic                            eff_low_side_monitor_ref_sel;
  logic                            eff_div_off;
  logic [1:0]                      eff_fmode;
  logic [csm_pkg::NUM_CH-1:0]      eff_trim;
  logic [1:0]                      eff_pwm_mode;
  logic [3:0]                      eff_drive;
  logic [csm_pkg::NUM_CH-1:0]      chan_cal;
  logic                            cal_any;

  // Clamp a seven-level pin code onto its legal range
  function automatic logic [2:0] seven_level(input logic [2:0] lvl);
    seven_level = (lvl > csm_pkg::SEVEN_LEVEL_MAX) ? csm_pkg::SEVEN_LEVEL_MAX : lvl;
  endfunction : seven_level

  // ------------------------------------------------------------
  // Input conditioning
  // ------------------------------------------------------------
  // All pins share one filter bank
  assign pin_raw = '{cal_pin, hs_cmp_above, ls_cmp_above, pwm_in, hw_variant_pin,
                     gain_pin_level, pwm_mode_pin_level, drive_current_select_pin_level,
                     trip_threshold_pin_level};

  input_filter #(
    .W (csm_pkg::PIN_W)
  ) u_filter (
    .clk  (clk),
    .nrst (nrst),
    .d    (pin_raw),
    .q    (pin_f)
  );

  // Strap is caught once the filter has settled after reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      strap_cnt_reg   <= '0;
      strap_taken_reg <= 1'b0;
      hw_variant_reg  <= 1'b0;
    end else if (!strap_taken_reg) begin
      if (strap_cnt_reg == csm_pkg::STRAP_SETTLE) begin
        strap_taken_reg <= 1'b1;
        hw_variant_reg  <= pin_f.hw_variant;
      end else begin
        strap_cnt_reg <= strap_cnt_reg + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------
  assign addr_ok   = hsel & htrans[csm_pkg::HTRANS_ACTIVE_BIT] & hready;
  assign wr_ctrl   = wr_pend_reg & (wr_addr_reg == csm_pkg::ADDR_CTRL);
  assign wr_cal    = wr_pend_reg & (wr_addr_reg == csm_pkg::ADDR_CAL);
  assign wr_status = wr_pend_reg & (wr_addr_reg == csm_pkg::ADDR_STATUS);

  // Address phase capture for the following data phase
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      wr_pend_reg <= addr_ok & hwrite & (hsize == csm_pkg::SIZE_WORD);
      wr_addr_reg <= haddr;
    end
  end

  // Always ready, always OKAY
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Status word view
  always_comb begin
    status           = '0;
    status.hw_variant = hw_variant_reg;
    status.shutdown  = shutdown_reg;
    status.ref_bidir = ~eff_div_off | cal_any;
    status.gain_eff  = cal_any ? csm_pkg::GAIN_40 : eff_gain;
    status.cal_busy  = (cal_state_reg == csm_pkg::CAL_TRIM);
    status.trim_done = (cal_state_reg == csm_pkg::CAL_HOLD);
    status.oc_flag   = oc_flag_reg;
  end

  // Read decode, unmapped reads return zero
  always_comb begin
    unique case (haddr)
      csm_pkg::ADDR_CTRL:   rd_data = ctrl_reg;
      csm_pkg::ADDR_CAL:    rd_data = {{(32 - csm_pkg::NUM_CH){1'b0}}, trim_bits_reg};
      csm_pkg::ADDR_STATUS: rd_data = status;
      default:              rd_data = '0;
    endcase
  end

  // Read data loaded in the address phase, stands through the data phase
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hrdata <= '0;
    end else if (addr_ok & ~hwrite) begin
      hrdata <= rd_data;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Configuration word, reserved bits held at zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_reg <= csm_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= hwdata & csm_pkg::CTRL_WMASK;
    end
  end

  // Per-channel offset trim request bits
  always_ff @(posedge clk) begin
    if (!nrst) begin
      trim_bits_reg <= '0;
    end else if (wr_cal) begin
      trim_bits_reg <= hwdata[csm_pkg::NUM_CH-1:0];
    end
  end

  // Overcurrent flags, write one to clear, a new event wins
  assign oc_clr = wr_status ? hwdata[csm_pkg::NUM_FET-1:0] : '0;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      oc_flag_reg <= '0;
    end else begin
      oc_flag_reg <= (oc_flag_reg & ~oc_clr) | oc_set;
    end
  end

  // ------------------------------------------------------------
  // Effective configuration
  // ------------------------------------------------------------
  always_comb begin
    if (hw_variant_reg) begin
      eff_gain     = pin_f.gain_lvl;
      eff_trip     = csm_pkg::HW_TRIP_CODE[seven_level(pin_f.trip_lvl)];
      eff_low_side_monitor_ref_sel   = csm_pkg::LOW_SIDE_MONITOR_REF_SEL_POS;
      eff_div_off  = 1'b0;
      eff_fmode    = csm_pkg::FM_LATCH;
      eff_trim     = '0;
      eff_pwm_mode = pin_f.mode_lvl;
      eff_drive    = {1'b0, seven_level(pin_f.drv_lvl)};
    end else begin
      eff_gain     = ctrl_reg.gain;
      eff_trip     = ctrl_reg.trip_level;
      eff_low_side_monitor_ref_sel   = ctrl_reg.drain_sense_mode_bit ? csm_pkg::LOW_SIDE_MONITOR_REF_SEL_NEG
                                                   : ctrl_reg.low_side_monitor_ref_sel;
      eff_div_off  = ctrl_reg.ref_div_off;
      eff_fmode    = ctrl_reg.fault_mode;
      eff_trim     = trim_bits_reg;
      eff_pwm_mode = ctrl_reg.pwm_mode;
      eff_drive    = ctrl_reg.drive_current;
    end
  end

  // ------------------------------------------------------------
  // Offset calibration
  // ------------------------------------------------------------
  // Pin requests every channel, bits request their own
  assign chan_cal = {csm_pkg::NUM_CH{pin_f.cal}} | eff_trim;
  assign cal_any  = |chan_cal;

  // Trim sequence: run for the trim time, then hold until released
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cal_state_reg <= csm_pkg::CAL_IDLE;
      cal_cnt_reg   <= '0;
    end else begin
      unique case (cal_state_reg)
        csm_pkg::CAL_IDLE: begin
          cal_cnt_reg <= '0;
          if (cal_any) begin
            cal_state_reg <= csm_pkg::CAL_TRIM;
          end
        end
        csm_pkg::CAL_TRIM: begin
          if (!cal_any) begin
            cal_state_reg <= csm_pkg::CAL_IDLE;
          end else if (cal_cnt_reg == csm_pkg::CAL_TRIM_LAST) begin
            cal_state_reg <= csm_pkg::CAL_HOLD;
          end else begin
            cal_cnt_reg <= cal_cnt_reg + 1'b1;
          end
        end
        csm_pkg::CAL_HOLD: begin
          if (!cal_any) begin
            cal_state_reg <= csm_pkg::CAL_IDLE;
          end
        end
        default: begin
          cal_state_reg <= csm_pkg::CAL_IDLE;
        end
      endcase
    end
  end

  // Amplifier controls during and after calibration
  always_ff @(posedge clk) begin
    if (!nrst) begin
      amp_gain_factor <= csm_pkg::GAIN_5;
      ref_bidir       <= 1'b1;
      amp_short       <= '0;
      load_disconnect <= '0;
      trim_run        <= '0;
    end else begin
      amp_gain_factor <= cal_any ? csm_pkg::GAIN_40 : eff_gain;
      ref_bidir       <= ~eff_div_off | cal_any;
      amp_short       <= chan_cal;
      load_disconnect <= chan_cal;
      trim_run        <= (cal_state_reg == csm_pkg::CAL_TRIM) ? chan_cal : '0;
    end
  end

  // ------------------------------------------------------------
  // Drain-source overcurrent monitors
  // ------------------------------------------------------------
  // High-side comparators in the low half, low-side in the high half
  assign fet_cmp = {pin_f.ls_cmp, pin_f.hs_cmp};

  for (genvar g = 0; g < csm_pkg::NUM_FET; g++) begin : g_ocp
    logic [csm_pkg::OCP_CNT_W-1:0] cnt_reg;

    // Time spent above trip, saturates at the deglitch count
    always_ff @(posedge clk) begin
      if (!nrst) begin
        cnt_reg <= '0;
      end else if (!fet_cmp[g]) begin
        cnt_reg <= '0;
      end else if (cnt_reg != csm_pkg::OCP_DEGLITCH_CNT) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end

    assign oc_hit[g] = fet_cmp[g] & (cnt_reg == csm_pkg::OCP_DEGLITCH_CNT);
  end

  // Ignore mode suppresses flags entirely
  assign oc_set = (eff_fmode == csm_pkg::FM_LATCH || eff_fmode == csm_pkg::FM_REPORT) ? oc_hit : '0;

  // Latched mode stops the gates until every flag is cleared
  always_ff @(posedge clk) begin
    if (!nrst) begin
      shutdown_reg <= 1'b0;
    end else if ((eff_fmode == csm_pkg::FM_LATCH) && (|oc_set)) begin
      shutdown_reg <= 1'b1;
    end else if (oc_flag_reg == '0) begin
      shutdown_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Pin-facing outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      low_side_monitor_ref_sel <= csm_pkg::LOW_SIDE_MONITOR_REF_SEL_POS;
      hs_mon_sel               <= csm_pkg::HS_MON_DRAIN_SWITCH;
      drain_source_trip_level  <= '0;
      gate_cmd                 <= '0;
      pwm_mode                 <= '0;
      drive_current_sel        <= '0;
    end else begin
      low_side_monitor_ref_sel <= eff_low_side_monitor_ref_sel;
      hs_mon_sel               <= csm_pkg::HS_MON_DRAIN_SWITCH;
      drain_source_trip_level  <= eff_trip;
      gate_cmd                 <= shutdown_reg ? '0 : pin_f.pwm;
      pwm_mode                 <= eff_pwm_mode;
      drive_current_sel        <= eff_drive;
    end
  end

  // Fault line only ever pulled low
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fault_flag_n_o  <= 1'b0;
      fault_flag_n_oe <= 1'b0;
    end else begin
      fault_flag_n_o  <= 1'b0;
      fault_flag_n_oe <= (|oc_flag_reg) | (|oc_set);
    end
  end

endmodule : cs_vds_monitor

// File: tb/controller_model.sv
module controller_model (
  input  logic       clk,
  input  logic       cal_req,
  input  logic [5:0] pwm_pat,
  input  logic       fault_flag_n_o,
  input  logic       fault_flag_n_oe,
  output logic       cal_pin,
  output logic [5:0] pwm_in,
  output logic       fault_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up on the fault line, the device can only pull it low
  assign fault_line = fault_flag_n_oe ? fault_flag_n_o : 1'b1;
  // Controller raises and drops the request, gates quiet meanwhile
  always @(posedge clk) begin
    cal_pin <= cal_req;
    pwm_in  <= (cal_req || cal_pin) ? 6'h00 : pwm_pat;
  end
endmodule : controller_model

// File: tb/cs_vds_monitor_properties.sv
module cs_vds_monitor_checker (
  input logic       clk,
  input logic       nrst,
  input logic       cal_pin,
  input logic [2:0] hs_cmp_above,
  input logic [2:0] ls_cmp_above,
  input logic       hreadyout,
  input logic       hresp,
  input logic [1:0] amp_gain_factor,
  input logic       ref_bidir,
  input logic [2:0] hs_mon_sel,
  input logic [2:0] amp_short,
  input logic [2:0] load_disconnect,
  input logic [2:0] trim_run,
  input logic       fault_flag_n_o,
  input logic       fault_flag_n_oe
);
  int trim_cnt;
  int oc_cnt;
  // Length of the running trim
  always_ff @(posedge clk) begin
    if (!nrst || trim_run == 3'h0) trim_cnt <= 0;
    else trim_cnt <= trim_cnt + 1;
  end
  // Cycles of unbroken comparator activity
  always_ff @(posedge clk) begin
    if (!nrst || {ls_cmp_above, hs_cmp_above} == 6'h00) oc_cnt <= 0;
    else if (oc_cnt < 1000) oc_cnt <= oc_cnt + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_pin_rise; $rose(cal_pin); endsequence
  sequence s_pin_held; cal_pin [*8]; endsequence
  property p_pin_cal; s_pin_rise ##0 s_pin_held |-> ##[0:2] amp_short == 3'h7; endproperty
  property p_cal_forces;
    amp_short != 3'h0 |-> amp_gain_factor == csm_pkg::GAIN_40 && ref_bidir;
  endproperty
  property p_short_disc; load_disconnect == amp_short; endproperty
  property p_trim_inside; trim_run != 3'h0 |-> (trim_run & ~amp_short) == 3'h0; endproperty
  property p_trim_len; trim_cnt <= csm_pkg::CAL_TRIM_CYCLES; endproperty
  property p_hs_mon; hs_mon_sel == csm_pkg::HS_MON_DRAIN_SWITCH; endproperty
  property p_pull_low; fault_flag_n_oe |-> !fault_flag_n_o; endproperty
  property p_oc_deglitch; $rose(fault_flag_n_oe) |-> oc_cnt > 100; endproperty
  property p_bus_okay; hreadyout && !hresp; endproperty
  a_pin_cal: assert property (p_pin_cal) else $error("pin request did not calibrate");
  a_cal_forces: assert property (p_cal_forces) else $error("gain or reference not forced");
  a_short_disc: assert property (p_short_disc) else $error("short and disconnect differ");
  a_trim_inside: assert property (p_trim_inside) else $error("trim outside calibration");
  a_trim_len: assert property (p_trim_len) else $error("trim ran too long");
  a_hs_mon: assert property (p_hs_mon) else $error("high-side monitor pair wrong");
  a_pull_low: assert property (p_pull_low) else $error("fault line driven high");
  a_oc_deglitch: assert property (p_oc_deglitch) else $error("overcurrent flagged early");
  a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not okay");
endmodule : cs_vds_monitor_checker

bind cs_vds_monitor cs_vds_monitor_checker chk (.clk(clk), .nrst(nrst), .cal_pin(cal_pin),
  .hs_cmp_above(hs_cmp_above), .ls_cmp_above(ls_cmp_above), .hreadyout(hreadyout), .hresp(hresp),
  .amp_gain_factor(amp_gain_factor), .ref_bidir(ref_bidir), .hs_mon_sel(hs_mon_sel),
  .amp_short(amp_short), .load_disconnect(load_disconnect), .trim_run(trim_run),
  .fault_flag_n_o(fault_flag_n_o), .fault_flag_n_oe(fault_flag_n_oe));

// File: tb/current_sense_cal_vds_monitor_bench.sv
module current_sense_cal_vds_monitor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        cal_req = 1'b0;
  logic [5:0]  pwm_pat = 6'h2A;
  logic [5:0]  oc_in = 6'h00;
  logic [31:0] ctrl_m = 32'h0;
  logic [2:0]  cal_m = 3'h0;
  logic        cal_p = 1'b0;
  logic [10:0] strap = 11'h0;
  logic        hreadyout, hresp, ref_bidir, ls_sel, cal_pin, fault_line, oe_n, o_n;
  logic [31:0] hrdata, q;
  logic [5:0]  pwm_in, gate_cmd;
  logic [2:0]  hs_sel, amp_short, disc, trim_run;
  logic [1:0]  gain, pmode;
  logic [3:0]  trip, drv;
  int          bad_count = 0;
  int          checked = 0;
  int          seed = 32;
  int          n;

  // 25 MHz clock
  always #20 clk = ~clk;

  cs_vds_monitor dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .cal_pin(cal_pin), .hs_cmp_above(oc_in[2:0]), .ls_cmp_above(oc_in[5:3]), .pwm_in(pwm_in),
    .hw_variant_pin(strap[10]), .gain_pin_level(strap[9:8]), .pwm_mode_pin_level(strap[7:6]),
    .drive_current_select_pin_level(strap[5:3]), .trip_threshold_pin_level(strap[2:0]), .amp_gain_factor(gain),
    .ref_bidir(ref_bidir), .low_side_monitor_ref_sel(ls_sel), .hs_mon_sel(hs_sel),
    .drain_source_trip_level(trip), .amp_short(amp_short), .load_disconnect(disc), .trim_run(trim_run),
    .gate_cmd(gate_cmd), .pwm_mode(pmode), .drive_current_sel(drv), .fault_flag_n_o(o_n), .fault_flag_n_oe(oe_n));

  controller_model partner (.clk(clk), .cal_req(cal_req), .pwm_pat(pwm_pat), .fault_flag_n_o(o_n),
    .fault_flag_n_oe(oe_n), .cal_pin(cal_pin), .pwm_in(pwm_in), .fault_line(fault_line));

  // ----------------
  // Compare and bus tasks
  // ----------------
  task automatic check_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_reg

  task automatic check_pin(input string what, input logic [5:0] exp, input logic [5:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_pin

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= csm_pkg::SIZE_WORD;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
    @(posedge clk);
  endtask : bus

  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check_reg("read data", exp, q & m);
  endtask : rd

  // Model of the configuration outputs
  task automatic check_cfg;
    check_pin("gain", (cal_p || cal_m != 3'h0) ? 2'h3 : ctrl_m[1:0], gain);
    check_pin("ref_bidir", !ctrl_m[6] || cal_p || cal_m != 3'h0, ref_bidir);
    check_pin("low_side_monitor_ref_sel", ctrl_m[8] || ctrl_m[7], ls_sel);
    check_pin("trip", ctrl_m[5:2], trip);
    check_pin("short", cal_p ? 3'h7 : cal_m, amp_short);
    check_pin("disconnect", cal_p ? 3'h7 : cal_m, disc);
    check_pin("hs_monitor", 3'h7, hs_sel);
    check_pin("mode", ctrl_m[16:11], {drv, pmode});
  endtask : check_cfg

  task automatic set_ctrl(input logic [31:0] v);
    ctrl_m = v & csm_pkg::CTRL_WMASK;
    bus(1'b1, csm_pkg::ADDR_CTRL, v);
    rd(csm_pkg::ADDR_CTRL, 32'hFFFF_FFFF, ctrl_m);
    @(negedge clk);
    check_cfg;
    @(posedge clk);
  endtask : set_ctrl

  task automatic wait_trim;
    n = 0;
    while (trim_run !== 3'h0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check_pin("trim_len", 1'b1, n <= csm_pkg::CAL_TRIM_CYCLES && n >= csm_pkg::CAL_TRIM_CYCLES - 8);
  endtask : wait_trim

  task automatic results;
    if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results;
  end

  // ----------------
  // Main sequence
  // ----------------
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check_cfg;
    @(posedge clk);
    rd(csm_pkg::ADDR_CAL, 32'hFFFF_FFFF, 32'h0);
    bus(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
    rd(32'h0000_0040, 32'hFFFF_FFFF, 32'h0);
    // Random configurations over every gain code
    for (int i = 0; i < 8; i++) begin
      set_ctrl(($random(seed) & ~32'h3) | 32'(i % 4));
      rd(csm_pkg::ADDR_STATUS, 32'h0000_0700, {21'h0, ~ctrl_m[6], ctrl_m[1:0], 8'h00});
    end
    // Register calibration of one channel, unidirectional reference
    set_ctrl(32'h0000_0041);
    cal_m = 3'h2;
    bus(1'b1, csm_pkg::ADDR_CAL, 32'h0000_0002);
    @(negedge clk);
    check_cfg;
    @(negedge clk);
    check_pin("trim_run", 3'h2, trim_run);
    wait_trim;
    check_cfg;
    @(posedge clk);
    rd(csm_pkg::ADDR_STATUS, 32'h0000_00C0, 32'h0000_0040);
    cal_m = 3'h0;
    bus(1'b1, csm_pkg::ADDR_CAL, 32'h0);
    @(negedge clk);
    check_cfg;
    @(posedge clk);
    // Calibration from the pin
    cal_req <= 1'b1;
    cal_p = 1'b1;
    repeat (10) @(negedge clk);
    check_cfg;
    wait_trim;
    @(posedge clk);
    cal_req <= 1'b0;
    cal_p = 1'b0;
    repeat (10) @(negedge clk);
    check_cfg;
    @(posedge clk);
    // Six monitors, latched fault mode, first one with a broken excess
    set_ctrl(32'h0);
    check_pin("gates_on", 6'h2A, gate_cmd);
    for (int m = 0; m < 6; m++) begin
      if (m == 0) begin
        oc_in <= 6'h01;
        repeat (60) @(posedge clk);
        oc_in <= 6'h00;
        repeat (10) @(posedge clk);
      end
      oc_in <= 6'h01 << m;
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (fault_line !== 1'b0 && n < 300);
      check_pin("oc_delay", 1'b1, n >= 101 && n <= 110);
      repeat (3) @(negedge clk);
      check_pin("gates_off", 6'h00, gate_cmd);
      @(posedge clk);
      oc_in <= 6'h00;
      repeat (8) @(posedge clk);
      rd(csm_pkg::ADDR_STATUS, 32'h0000_003F, 32'h1 << m);
      bus(1'b1, csm_pkg::ADDR_STATUS, 32'h0000_003F);
      repeat (10) @(negedge clk);
      check_pin("fault_line", 1'b1, fault_line);
      check_pin("gates_on", 6'h2A, gate_cmd);
      @(posedge clk);
    end
    set_ctrl(32'h0001_FF7F);
    // Reset in mid-run
    nrst <= 1'b0;
    strap <= 11'h67B;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    ctrl_m = 32'h0;
    @(negedge clk);
    check_cfg;
    @(posedge clk);
    rd(csm_pkg::ADDR_CTRL, 32'hFFFF_FFFF, 32'h0);
    repeat (10) @(negedge clk);
    check_reg("strap", {2'h2, 4'h7, 2'h1, 4'h6}, {gain, trip, pmode, drv});
    results;
  end
endmodule : current_sense_cal_vds_monitor_bench
